//--- verilog/wrsc_regs.svh
// Constants for the wake-up receiver serial command unit
`ifndef WRSC_REGS_SVH
`define WRSC_REGS_SVH
// Command byte field positions, reset values, gain limits and steps, resync pulse count
`define WRSC_CMD_FREEZE       7
`define WRSC_CMD_CHSEL_HI     6
`define WRSC_CMD_CHSEL_LO     5
`define WRSC_CMD_READ         4
`define WRSC_CMD_SOFT_RESET   3
`define WRSC_CMD_FAST_GAIN    2
`define WRSC_CMD_TEST         0
`define WRSC_CMD_RESET        8'h00
`define WRSC_CMD_CHSEL_MASK   8'h60
`define WRSC_DATA_RESET       8'h00
`define WRSC_GAIN_MAX         8'hFF
`define WRSC_GAIN_STEP_STD    9'h001
`define WRSC_GAIN_STEP_FAST   9'h002
`define WRSC_RESYNC_PULSES    3'h4
// Host APB register offsets and control register bit positions
`define WRSC_OFF_COMMAND      8'h00
`define WRSC_OFF_CONTROL      8'h04
`define WRSC_OFF_STATUS       8'h08
`define WRSC_OFF_RXDATA       8'h0C
`define WRSC_CTRL_READOUT     0
`define WRSC_CTRL_RESYNC      1
// Timing
`define WRSC_PCLK_NS          10
`define WRSC_READ_GAP_NS      50000
`define WRSC_READ_GAP_CYCLES  (`WRSC_READ_GAP_NS / `WRSC_PCLK_NS + 1)
`define WRSC_HALF_CYCLES      16
`endif

//--- verilog/wrsc_pkg.sv
// Types shared by both ends of the serial command link
package wrsc_pkg;
    typedef enum logic [2:0] {
        DEV_IDLE  = 3'b001,
        DEV_CMD   = 3'b010,
        DEV_READ  = 3'b100
    } wrsc_dev_phase_type;
    typedef enum logic [4:0] {
        HOST_IDLE   = 5'b00001,
        HOST_CMD    = 5'b00010,
        HOST_GAP    = 5'b00100,
        HOST_READ   = 5'b01000,
        HOST_RESYNC = 5'b10000
    } wrsc_host_state_type;
endpackage

//--- verilog/wrsc_link_if.sv
// Two-wire link between host controller and receiver command unit
interface wrsc_link_if;
    logic shift_clock_n;    // Shift clock, idles high, host drives
    logic host_io_n;        // Host data out
    logic host_io_oe_n;     // Host drives data line when low
    logic dev_io_n;         // Device data out
    logic dev_io_oe_n;      // Device drives data line when low
    logic serial_io_n;      // Resolved data line, pulled high when free
    // Wired-and with pull-up; contention shows as low
    assign serial_io_n = (host_io_oe_n | host_io_n) & (dev_io_oe_n | dev_io_n);
    modport host (output shift_clock_n, output host_io_n, output host_io_oe_n,
                  input serial_io_n);
    modport device (input shift_clock_n, input serial_io_n,
                    output dev_io_n, output dev_io_oe_n);
endinterface

//--- verilog/wrsc_device.sv
// Receiver end: command shift register, gain counter and readout
//
// Local design decisions: the register addresses and register access over APB.
`include "wrsc_regs.svh"
module wrsc_device (
    input  wire logic       pclk,                // System clock
    input  wire logic       presetn,             // Async reset, active low
    wrsc_link_if.device     link,                // Two-wire link
    input  wire logic       gain_step,           // Front end asks one gain step
    output logic      [2:0] coil_enable,         // Coil 3..1 input enables
    output logic      [7:0] gain_value,          // Gain control counter
    output logic            gain_frozen,         // Freeze bit
    output logic            fast_gain_select,    // Fast gain bit
    output logic            factory_test_select, // Test bit
    output logic            low_power_state      // Set by soft reset
);
    logic [1:0] sclk_sync;
    logic [1:0] io_sync;
    logic       sclk_d;
    logic       io_d;
    logic       sclk_fall;
    logic       sclk_rise;
    logic       io_rise;
    logic [2:0] resync_cnt;
    logic       iface_clear;
    wrsc_pkg::wrsc_dev_phase_type phase;
    logic [2:0] bit_cnt;
    logic [7:0] shifter;
    logic       read_armed;
    logic       cmd_done;
    logic [7:0] cmd_byte;
    logic [7:0] command_control_reg;
    logic [7:0] data_reg;
    logic       soft_clear;
    logic       gain_reset;
    logic [8:0] gain_sum;

    // Two flops on each pin before any logic, third for edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_sync <= 2'b11;
            io_sync   <= 2'b11;
            sclk_d    <= 1'b1;
            io_d      <= 1'b1;
        end else begin
            sclk_sync <= {sclk_sync[0], link.shift_clock_n};
            io_sync   <= {io_sync[0], link.serial_io_n};
            sclk_d    <= sclk_sync[1];
            io_d      <= io_sync[1];
        end
    end

    assign sclk_fall = sclk_d & ~sclk_sync[1];
    assign sclk_rise = ~sclk_d & sclk_sync[1];
    assign io_rise   = ~io_d & io_sync[1];

    // Data pulses within one clock-low phase; normal shifting gives one at most
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resync_cnt <= 3'h0;
        end else if (sclk_sync[1] || iface_clear) begin
            resync_cnt <= 3'h0;
        end else if (io_rise && link.dev_io_oe_n) begin
            resync_cnt <= resync_cnt + 3'h1;
        end
    end

    assign iface_clear = !sclk_sync[1] && io_rise && link.dev_io_oe_n
                         && (resync_cnt == `WRSC_RESYNC_PULSES - 3'h1);

    assign cmd_byte   = {shifter[6:0], io_sync[1]};
    // Register still holds the old byte at cmd_done, so take the bit from the shifter
    assign soft_clear = cmd_done && shifter[`WRSC_CMD_SOFT_RESET];

    // Shift engine: command in on rising, data out on falling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase            <= wrsc_pkg::DEV_IDLE;
            bit_cnt          <= 3'h0;
            shifter          <= 8'h00;
            read_armed       <= 1'b0;
            cmd_done         <= 1'b0;
            link.dev_io_n    <= 1'b1;
            link.dev_io_oe_n <= 1'b1;
        end else if (iface_clear || soft_clear) begin
            phase            <= wrsc_pkg::DEV_IDLE;
            bit_cnt          <= 3'h0;
            shifter          <= 8'h00;
            read_armed       <= 1'b0;
            cmd_done         <= 1'b0;
            link.dev_io_n    <= 1'b1;
            link.dev_io_oe_n <= 1'b1;
        end else begin
            cmd_done <= 1'b0;
            case (phase)
                wrsc_pkg::DEV_IDLE: begin
                    // Rising edges before a falling one are ignored
                    if (sclk_fall && read_armed) begin
                        phase            <= wrsc_pkg::DEV_READ;
                        read_armed       <= 1'b0;
                        link.dev_io_n    <= data_reg[7];
                        link.dev_io_oe_n <= 1'b0;
                        shifter          <= {data_reg[6:0], 1'b0};
                        bit_cnt          <= 3'h0;
                    end else if (sclk_fall) begin
                        phase   <= wrsc_pkg::DEV_CMD;
                        bit_cnt <= 3'h0;
                    end
                end
                wrsc_pkg::DEV_CMD: begin
                    if (sclk_rise) begin
                        shifter <= cmd_byte;
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            phase      <= wrsc_pkg::DEV_IDLE;
                            cmd_done   <= 1'b1;
                            read_armed <= cmd_byte[`WRSC_CMD_READ];
                        end
                    end
                end
                wrsc_pkg::DEV_READ: begin
                    if (sclk_fall) begin
                        link.dev_io_n <= shifter[7];
                        shifter       <= {shifter[6:0], 1'b0};
                    end else if (sclk_rise) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            phase            <= wrsc_pkg::DEV_IDLE;
                            link.dev_io_n    <= 1'b1;
                            link.dev_io_oe_n <= 1'b1;
                        end
                    end
                end
                default: begin
                    phase <= wrsc_pkg::DEV_IDLE;
                end
            endcase
        end
    end

    // Command register; a completed byte lands here one cycle after cmd_done
    // is seen, so cmd_done uses the byte still held in the shifter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_control_reg <= `WRSC_CMD_RESET;
            data_reg            <= `WRSC_DATA_RESET;
            low_power_state     <= 1'b1;
        end else if (cmd_done && shifter[`WRSC_CMD_SOFT_RESET]) begin
            command_control_reg <= `WRSC_CMD_RESET;
            data_reg            <= `WRSC_DATA_RESET;
            low_power_state     <= 1'b1;
        end else if (cmd_done) begin
            command_control_reg <= shifter;
            low_power_state     <= 1'b0;
            if (shifter[`WRSC_CMD_READ]) begin
                data_reg <= gain_value;
            end
        end
    end

    // Freeze-only and read commands keep the gain; channel changes never do
    assign gain_reset = cmd_done && (shifter[`WRSC_CMD_SOFT_RESET]
        || ((shifter & `WRSC_CMD_CHSEL_MASK) != (command_control_reg & `WRSC_CMD_CHSEL_MASK))
        || (!shifter[`WRSC_CMD_READ]
            && ((shifter & ~(`WRSC_CMD_CHSEL_MASK | 8'h80)) != 8'h00)));

    assign gain_sum = {1'b0, gain_value} + (fast_gain_select ? `WRSC_GAIN_STEP_FAST
                                                             : `WRSC_GAIN_STEP_STD);

    // Gain counter: zero is highest sensitivity, saturates at full range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_value <= 8'h00;
        end else if (gain_reset) begin
            gain_value <= 8'h00;
        end else if (gain_step && !gain_frozen) begin
            gain_value <= gain_sum[8] ? `WRSC_GAIN_MAX : gain_sum[7:0];
        end
    end

    // Decoded mode outputs, registered from the command register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coil_enable         <= 3'b111;
            gain_frozen         <= 1'b0;
            fast_gain_select    <= 1'b0;
            factory_test_select <= 1'b0;
        end else begin
            gain_frozen         <= command_control_reg[`WRSC_CMD_FREEZE];
            fast_gain_select    <= command_control_reg[`WRSC_CMD_FAST_GAIN];
            factory_test_select <= command_control_reg[`WRSC_CMD_TEST];
            case ({command_control_reg[`WRSC_CMD_CHSEL_HI],
                   command_control_reg[`WRSC_CMD_CHSEL_LO]})
                2'b01:   coil_enable <= 3'b001;
                2'b10:   coil_enable <= 3'b010;
                2'b11:   coil_enable <= 3'b100;
                default: coil_enable <= 3'b111;
            endcase
        end
    end
endmodule

//--- verilog/wrsc_host.sv
// Host end: APB-programmed driver of the two-wire command link
`include "wrsc_regs.svh"
module wrsc_host #(
    parameter int HALF_CYCLES = `WRSC_HALF_CYCLES,     // pclk per shift clock half
    parameter int GAP_CYCLES  = `WRSC_READ_GAP_CYCLES  // Wait after read command
) (
    input  wire logic        pclk,     // System clock
    input  wire logic        presetn,  // Async reset, active low
    input  wire logic        psel,     // APB select
    input  wire logic        penable,  // APB access phase
    input  wire logic        pwrite,   // APB write
    input  wire logic  [7:0] paddr,    // APB byte address
    input  wire logic [31:0] pwdata,   // APB write data
    output logic      [31:0] prdata,   // APB read data
    output logic             pready,   // APB ready
    output logic             pslverr,  // APB error, unmapped address
    wrsc_link_if.host        link      // Two-wire link
);
    wrsc_pkg::wrsc_host_state_type state;
    logic [1:0]  io_sync;
    logic [15:0] div_cnt;
    logic [15:0] gap_cnt;
    logic [2:0]  bit_cnt;
    logic [7:0]  tx_byte;
    logic [7:0]  rx_byte;
    logic        tick;
    logic        wr;
    logic        mapped;
    logic        busy;

    assign pready = 1'b1;
    assign wr     = psel && penable && pwrite;
    assign busy   = (state != wrsc_pkg::HOST_IDLE);
    assign mapped = (paddr == `WRSC_OFF_COMMAND) || (paddr == `WRSC_OFF_CONTROL)
                    || (paddr == `WRSC_OFF_STATUS) || (paddr == `WRSC_OFF_RXDATA);
    assign pslverr = psel && penable && !mapped;
    assign tick    = (div_cnt == 16'h0000);

    // Read data is combinational from registers; zero when unmapped
    always_comb begin
        prdata = 32'h0000_0000;
        case (paddr)
            `WRSC_OFF_COMMAND: prdata = {24'h00_0000, tx_byte};
            `WRSC_OFF_STATUS:  prdata = {30'h0000_0000, (gap_cnt != 16'h0000), busy};
            `WRSC_OFF_RXDATA:  prdata = {24'h00_0000, rx_byte};
            default:           prdata = 32'h0000_0000;
        endcase
    end

    // Data pin from the device passes two flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_sync <= 2'b11;
        end else begin
            io_sync <= {io_sync[0], link.serial_io_n};
        end
    end

    // Half-period divider, restarted at each transfer start; held through the
    // gap so the first readout low half is a full half, not a leftover
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 16'h0000;
        end else if (!busy || tick || state == wrsc_pkg::HOST_GAP) begin
            div_cnt <= 16'(HALF_CYCLES - 1);
        end else begin
            div_cnt <= div_cnt - 16'h0001;
        end
    end

    // Gap timer armed by a finished read command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt <= 16'h0000;
        end else if (state == wrsc_pkg::HOST_CMD && tick && link.shift_clock_n
                     && bit_cnt == 3'h7 && tx_byte[`WRSC_CMD_READ]) begin
            gap_cnt <= 16'(GAP_CYCLES);
        end else if (gap_cnt != 16'h0000) begin
            gap_cnt <= gap_cnt - 16'h0001;
        end
    end

    // Transfer engine; writes while busy are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state              <= wrsc_pkg::HOST_IDLE;
            bit_cnt            <= 3'h0;
            tx_byte            <= 8'h00;
            rx_byte            <= 8'h00;
            link.shift_clock_n <= 1'b1;
            link.host_io_n     <= 1'b1;
            link.host_io_oe_n  <= 1'b1;
        end else begin
            case (state)
                wrsc_pkg::HOST_IDLE: begin
                    bit_cnt <= 3'h0;
                    if (wr && paddr == `WRSC_OFF_COMMAND) begin
                        // Software keeps test bit 0 and read's channel bits current
                        tx_byte            <= pwdata[7:0];
                        state              <= wrsc_pkg::HOST_CMD;
                        link.shift_clock_n <= 1'b0;
                        link.host_io_n     <= pwdata[7];
                        link.host_io_oe_n  <= 1'b0;
                    end else if (wr && paddr == `WRSC_OFF_CONTROL
                                 && pwdata[`WRSC_CTRL_RESYNC]) begin
                        state              <= wrsc_pkg::HOST_RESYNC;
                        link.shift_clock_n <= 1'b0;
                        link.host_io_n     <= 1'b0;
                        link.host_io_oe_n  <= 1'b0;
                    end else if (wr && paddr == `WRSC_OFF_CONTROL
                                 && pwdata[`WRSC_CTRL_READOUT]) begin
                        state <= wrsc_pkg::HOST_GAP;
                    end
                end
                wrsc_pkg::HOST_CMD: begin
                    if (tick && !link.shift_clock_n) begin
                        link.shift_clock_n <= 1'b1;
                    end else if (tick && bit_cnt == 3'h7) begin
                        state             <= wrsc_pkg::HOST_IDLE;
                        link.host_io_n    <= 1'b1;
                        link.host_io_oe_n <= 1'b1;
                    end else if (tick) begin
                        bit_cnt            <= bit_cnt + 3'h1;
                        link.shift_clock_n <= 1'b0;
                        link.host_io_n     <= tx_byte[3'h6 - bit_cnt];
                    end
                end
                wrsc_pkg::HOST_GAP: begin
                    // Readout waits until the device has refreshed its data
                    if (gap_cnt == 16'h0000) begin
                        state              <= wrsc_pkg::HOST_READ;
                        link.shift_clock_n <= 1'b0;
                    end
                end
                wrsc_pkg::HOST_READ: begin
                    if (tick && !link.shift_clock_n) begin
                        rx_byte            <= {rx_byte[6:0], io_sync[1]};
                        link.shift_clock_n <= 1'b1;
                    end else if (tick && bit_cnt == 3'h7) begin
                        state <= wrsc_pkg::HOST_IDLE;
                    end else if (tick) begin
                        bit_cnt            <= bit_cnt + 3'h1;
                        link.shift_clock_n <= 1'b0;
                    end
                end
                wrsc_pkg::HOST_RESYNC: begin
                    // Line starts low; four rises land while the clock is still low,
                    // the clock only rises one half after the last of them
                    if (tick && bit_cnt == 3'h7) begin
                        state              <= wrsc_pkg::HOST_IDLE;
                        link.host_io_n     <= 1'b1;
                        link.host_io_oe_n  <= 1'b1;
                        link.shift_clock_n <= 1'b1;
                    end else if (tick) begin
                        bit_cnt        <= bit_cnt + 3'h1;
                        link.host_io_n <= ~bit_cnt[0];
                    end
                end
                default: begin
                    state <= wrsc_pkg::HOST_IDLE;
                end
            endcase
        end
    end
endmodule

//--- bench/wrsc_sva.sv
// Link checker: timing and ownership rules on the two-wire interface
module wrsc_sva #(
    parameter int HALF = 16  // pclk per shift clock half
) (
    input wire logic pclk,          // System clock
    input wire logic presetn,       // Async reset, active low
    input wire logic shift_clock_n, // Shift clock
    input wire logic host_io_n,     // Host data out
    input wire logic host_io_oe_n,  // Host drive enable, low active
    input wire logic dev_io_n,      // Device data out
    input wire logic dev_io_oe_n    // Device drive enable, low active
);
    timeunit 1ns;
    timeprecision 1ps;
    int low_cnt;
    int drv_cnt;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Length of the present low clock phase and of the device drive window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= 0;
            drv_cnt <= 0;
        end else begin
            low_cnt <= shift_clock_n ? 0 : low_cnt + 1;
            drv_cnt <= dev_io_oe_n ? 0 : drv_cnt + 1;
        end
    end
    no_contention_a: assert property (!(!dev_io_oe_n && !host_io_oe_n))
        else $error("both ends drive the data line");
    host_start_a: assert property ($fell(host_io_oe_n) |-> $fell(shift_clock_n))
        else $error("host drive starts off a falling clock");
    low_half_a: assert property (
        $rose(shift_clock_n) && low_cnt < 2 * HALF |-> low_cnt == HALF)
        else $error("low clock half has wrong length");
    cmd_hold_a: assert property ($rose(shift_clock_n) && !host_io_oe_n |->
        $stable(host_io_n) ##1 $stable(host_io_n)[*3]) else $error("data moves at rising clock");
    host_change_a: assert property (
        $changed(host_io_n) && !host_io_oe_n && $past(!host_io_oe_n) |-> !shift_clock_n)
        else $error("host data moves while clock high");
    dev_change_a: assert property (
        !dev_io_oe_n && $past(!dev_io_oe_n) && $changed(dev_io_n)
        |-> !shift_clock_n && low_cnt < 6)
        else $error("readout bit not off falling edge");
    dev_start_a: assert property ($fell(dev_io_oe_n) |-> !shift_clock_n && low_cnt < 6)
        else $error("device drive starts away from falling edge");
    drive_len_a: assert property ($rose(dev_io_oe_n) |->
        drv_cnt >= 15 * HALF - 4 && drv_cnt <= 15 * HALF + 4) else $error("readout length wrong");
    io_release_a: assert property (host_io_oe_n |-> host_io_n)
        else $error("released host data not high");
endmodule

//--- bench/wrsc_test.sv
// Self-checking bench: host end and receiver end joined over the link
module wrsc_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        gain_step = 1'b0;
    logic [2:0]  coil;
    logic [7:0]  gain;
    wire  [3:0]  flags;
    logic        chk = 1'b0;
    logic [31:0] rdata;
    logic [31:0] seed = 32'h0000_cc4d;
    logic [33:0] exp_q[$];
    int          bad_count = 0;
    int          compares = 0;
    int          cyc = 0;
    wrsc_link_if link();
    // Short halves and gap keep the run brief
    wrsc_host #(.HALF_CYCLES(8), .GAP_CYCLES(20)) u_wrsc_host (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    wrsc_device u_wrsc_device (.pclk(pclk), .presetn(presetn), .link(link),
        .gain_step(gain_step), .coil_enable(coil), .gain_value(gain), .gain_frozen(flags[3]),
        .fast_gain_select(flags[2]), .factory_test_select(flags[1]), .low_power_state(flags[0]));
    wrsc_sva #(.HALF(8)) u_sva (.pclk(pclk), .presetn(presetn),
        .shift_clock_n(link.shift_clock_n), .host_io_n(link.host_io_n),
        .host_io_oe_n(link.host_io_oe_n), .dev_io_n(link.dev_io_n), .dev_io_oe_n(link.dev_io_oe_n));
    always #5 pclk = ~pclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [2:0] coil_of(input int i);
        return (i == 0) ? 3'b111 : 3'(1 << (i - 1));
    endfunction
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One APB transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // One quiet edge, so a following call never reassigns psel in this step
        @(posedge pclk);
    endtask
    // Note carries the error flag too: only the four word offsets are mapped
    task automatic rd(input logic [7:0] a, input logic [31:0] v);
        exp_q.push_back({1'b0, (a > 8'h0C) || (a[1:0] != 2'b00), v});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic idle();
        do apb(1'b0, 8'h08, 32'h0000_0000);
        while (rdata[0] !== 1'b0);
    endtask
    task automatic cmd(input logic [7:0] c);
        apb(1'b1, 8'h00, {24'h00_0000, c});
        idle();
        repeat (6) @(posedge pclk);
    endtask
    // Snapshot of receiver outputs, f = frozen, fast, low power
    task automatic dev_is(input logic [2:0] c, input logic [7:0] g, input logic [2:0] f);
        exp_q.push_back({1'b1, 1'b0, 17'h0_0000, c, g, f[2:1], 1'b0, f[0]});
        chk <= 1'b1;
        @(posedge pclk);
        chk <= 1'b0;
    endtask
    // Random gain steps; the expected count follows each high sample
    task automatic steps(input int n, input int inc, inout logic [7:0] g);
        repeat (n) begin
            seed = lfsr(seed);
            gain_step <= seed[0];
            if (seed[0]) g = (int'(g) + inc > 255) ? 8'hff : 8'(int'(g) + inc);
            @(posedge pclk);
        end
        gain_step <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    // Oldest note against each finished read or snapshot
    always @(posedge pclk) begin
        logic [33:0] e;
        logic [32:0] a;
        if (chk || (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0
                    && exp_q.size() > 0)) begin
            e = exp_q.pop_front();
            a = chk ? {18'h0_0000, coil, gain, flags} : {pslverr, prdata};
            compares++;
            if (a !== e[32:0]) begin
                bad_count++;
                $display("Error %s expected %h seen %h", e[33] ? "device" : "apb read",
                         e[32:0], a);
            end
        end
    end
    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            final_report();
        end
    end
    initial begin
        logic [7:0] g;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        dev_is(3'b111, 8'h00, 3'b001);
        rd(8'h10, 32'h0000_0000);
        cmd(8'h24);
        g = 8'h00;
        dev_is(3'b001, g, 3'b010);
        steps(60, 2, g);
        dev_is(3'b001, g, 3'b010);
        cmd(8'h34);
        dev_is(3'b001, g, 3'b010);
        apb(1'b1, 8'h04, 32'h0000_0001);
        idle();
        rd(8'h0C, {24'h00_0000, g});
        cmd(8'hA0);
        steps(20, 0, g);
        dev_is(3'b001, g, 3'b100);
        for (int i = 0; i < 4; i++) begin
            cmd({1'b0, 2'(i), 5'h00});
            g = 8'h00;
            dev_is(coil_of(i), g, 3'b000);
            steps(10, 1, g);
            dev_is(coil_of(i), g, 3'b000);
        end
        apb(1'b1, 8'h04, 32'h0000_0002);
        idle();
        cmd(8'h04);
        dev_is(3'b111, 8'h00, 3'b010);
        steps(8, 2, g);
        cmd(8'h08);
        dev_is(3'b111, 8'h00, 3'b001);
        final_report();
    end
endmodule
